// ==== rtl/nfccfg_defines.vh ====
// Constants for the frontend configuration store: offsets, fields, codes.
// Assumes registers of up to 32 bits placed one per aligned APB word.
`ifndef NFCCFG_DEFINES_VH
`define NFCCFG_DEFINES_VH

// ==========================================================================
// Register word indices; the byte address is four times these
`define NFCCFG_MISC_CONTROL 12'h0e8
`define NFCCFG_TYPE_A_DELAY_BASE 12'h0e9
`define NFCCFG_TYPE_B_DELAY_BASE 12'h0ea
`define NFCCFG_TYPE_F_DELAY_BASE 12'h0eb
`define NFCCFG_VICINITY_DELAY_BASE 12'h0ec
`define NFCCFG_ISO18000_V2_DELAY_BASE 12'h0ed
`define NFCCFG_ISO18000_V4_DELAY_BASE 12'h0ee
`define NFCCFG_RESERVED_EF 12'h0ef
`define NFCCFG_TEST_OUTPUT_KIND 12'h0f0
`define NFCCFG_TEST_SIGNAL_GROUP 12'h0f1
`define NFCCFG_TEST_LINE_SWAP 12'h0f2
`define NFCCFG_PAD_ROUTE_COUNT 12'h0f3
`define NFCCFG_PAD_ROUTE_ENTRY0 12'h0f4
`define NFCCFG_TECH_MASK 12'h100
`define NFCCFG_SYS_TRIM 12'h104
`define NFCCFG_TEST_ENABLE 12'h108
`define NFCCFG_STATUS 12'h10c
`define NFCCFG_DELAY_SELECT 12'h110
`define NFCCFG_DELAY_RESULT 12'h114
`define NFCCFG_PAD_ROUTE_NUM 3'h4

// ==========================================================================
// Miscellaneous control fields
`define NFCCFG_MISC_DELAY_EN 0
`define NFCCFG_MISC_TIMER_LO 1
`define NFCCFG_MISC_REG_OUT 3
`define NFCCFG_MISC_TRIM_CORR 4

// ==========================================================================
// Technology bitmask fields
`define NFCCFG_TECH_B_LO 20
`define NFCCFG_TECH_F212 24
`define NFCCFG_TECH_F424 25
`define NFCCFG_TECH_V100 26
`define NFCCFG_TECH_V10 27
`define NFCCFG_TECH_M3 28

// ==========================================================================
// Test bus codes
`define NFCCFG_KIND_ANALOG 8'h01
`define NFCCFG_KIND_DIGITAL 8'h02

// ==========================================================================
// Reset values
`define NFCCFG_RST_BYTE 8'h00
`define NFCCFG_RST_WORD 32'h00000000

`endif

// ==== rtl/nfccfg_store.v ====
// Configuration store of the contactless frontend, with APB access,
// delay scaling and test bus decode.
// Assumes one clock, an APB master, and synchronous inputs.
`timescale 1ns/1ps
`include "nfccfg_defines.vh"

// Notes on behaviour
// - Mask bits 20-23 select type B rates
// - Mask bits 24,25 select type F rates
// - Mask bits 26-28 select vicinity, mode 3
// - Misc bit 0 enables digital delay
// - Misc bits 2-1 pick timer 0-2
// - Misc bit 3 enables regulated output
// - Bit 4 adds system trim field
// - Only top-rate delays stored; rest derived
// - Type A lower rates scale 2,4,8
// - Type B lower rates scale 2,4,8
// - Type F 212 is twice base
// - Vicinity V10 rate twice base
// - Two separate mode 3 delay bases
// - Kind 1 analog, kind 2 digital
// - Signal group only valid codes accepted
// - Swap byte routes line 0/1
// - Count gives number of valid routes
// - Route entry: pad nibble, bus bit
// - Test output only when enabled
module nfccfg_store (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [7:0] i_test_bus,
  input wire [7:0] i_stored_trim,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_auto_delay_enable,
  output reg [2:0] o_timer_select,
  output reg o_regulated_output_pin,
  output reg [7:0] o_gain_trim,
  output reg [10:0] o_active_delay,
  output reg o_analog_test_output,
  output reg o_digital_test_output,
  output reg [3:0] o_test_pad_out
);

  // ========================================================================
  // Storage
  reg [7:0] misc_q;
  reg [7:0] dly_q [0:5];
  reg [7:0] rsvd_ef_q;
  reg [7:0] kind_q;
  reg [7:0] group_q;
  reg [7:0] swap_q;
  reg [7:0] count_q;
  reg [7:0] route_q [0:3];
  reg [31:0] tech_q;
  reg [31:0] sys_q;
  reg test_en_q;
  reg [2:0] dsel_q;

  // Digital and analog group code check
  function group_ok;
    input [7:0] kind;
    input [7:0] code;
    begin
      group_ok = 1'b0;
      if (kind == `NFCCFG_KIND_DIGITAL) begin
        case (code)
          8'h00, 8'h01, 8'h10, 8'h1b, 8'h1d,
          8'h30, 8'h58, 8'h70, 8'h73: group_ok = 1'b1;
          default: group_ok = 1'b0;
        endcase
      end else if (kind == `NFCCFG_KIND_ANALOG) begin
        case (code)
          8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
          8'h06, 8'h07, 8'h09, 8'h0a: group_ok = 1'b1;
          default: group_ok = 1'b0;
        endcase
      end
    end
  endfunction

  // Delay base times two to the power sh, widened so 8x still fits
  function [10:0] scale_dly;
    input [7:0] base;
    input [1:0] sh;
    begin
      case (sh)
        2'd0: scale_dly = {3'h0, base};
        2'd1: scale_dly = {2'h0, base, 1'b0};
        2'd2: scale_dly = {1'b0, base, 2'h0};
        2'd3: scale_dly = {base, 3'h0};
        default: scale_dly = {3'h0, base};
      endcase
    end
  endfunction

  // Shift for the highest set type A rate bit; none counts as 106
  function [1:0] a_rate;
    input [3:0] bits;
    begin
      if (bits[3])
        a_rate = 2'd0;
      else if (bits[2])
        a_rate = 2'd1;
      else if (bits[1])
        a_rate = 2'd2;
      else
        a_rate = 2'd3;
    end
  endfunction

  // One-hot timer select; the unused code 11b selects none
  function [2:0] timer_onehot;
    input [1:0] code;
    begin
      case (code)
        2'b00: timer_onehot = 3'b001;
        2'b01: timer_onehot = 3'b010;
        2'b10: timer_onehot = 3'b100;
        default: timer_onehot = 3'b000;
      endcase
    end
  endfunction

  // Route entry names this pad and a plain test bus bit
  function route_hit;
    input [7:0] entry;
    input integer pad;
    begin
      route_hit = (entry[7:4] == pad) && (entry[3] == 1'b0);
    end
  endfunction

  // ========================================================================
  // APB access; pready answers one cycle into the access phase
  wire acc = i_psel & i_penable & ~o_pready;
  wire [7:0] wb = i_pwdata[7:0];
  reg mapped;
  reg [31:0] rd;

  // Each byte register sits in its own word; the word index is the
  // register offset, so software uses four times the offset as address.
  wire [11:0] idx = {2'b00, i_paddr[11:2]};
  wire [11:0] ws = idx;

  always @* begin
    mapped = 1'b1;
    rd = `NFCCFG_RST_WORD;
    case (idx)
      `NFCCFG_MISC_CONTROL: rd = {24'h000000, misc_q};
      `NFCCFG_TYPE_A_DELAY_BASE: rd = {24'h000000, dly_q[0]};
      `NFCCFG_TYPE_B_DELAY_BASE: rd = {24'h000000, dly_q[1]};
      `NFCCFG_TYPE_F_DELAY_BASE: rd = {24'h000000, dly_q[2]};
      `NFCCFG_VICINITY_DELAY_BASE: rd = {24'h000000, dly_q[3]};
      `NFCCFG_ISO18000_V2_DELAY_BASE: rd = {24'h000000, dly_q[4]};
      `NFCCFG_ISO18000_V4_DELAY_BASE: rd = {24'h000000, dly_q[5]};
      `NFCCFG_RESERVED_EF: rd = {24'h000000, rsvd_ef_q};
      `NFCCFG_TEST_OUTPUT_KIND: rd = {24'h000000, kind_q};
      `NFCCFG_TEST_SIGNAL_GROUP: rd = {24'h000000, group_q};
      `NFCCFG_TEST_LINE_SWAP: rd = {24'h000000, swap_q};
      `NFCCFG_PAD_ROUTE_COUNT: rd = {24'h000000, count_q};
      12'h0f4: rd = {24'h000000, route_q[0]};
      12'h0f5: rd = {24'h000000, route_q[1]};
      12'h0f6: rd = {24'h000000, route_q[2]};
      12'h0f7: rd = {24'h000000, route_q[3]};
      `NFCCFG_TECH_MASK: rd = tech_q;
      `NFCCFG_SYS_TRIM: rd = sys_q;
      `NFCCFG_TEST_ENABLE: rd = {31'h00000000, test_en_q};
      `NFCCFG_STATUS: rd = {29'h00000000, group_ok(kind_q, group_q),
        o_digital_test_output, o_analog_test_output};
      `NFCCFG_DELAY_SELECT: rd = {29'h00000000, dsel_q};
      `NFCCFG_DELAY_RESULT: rd = {21'h000000, o_active_delay};
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= `NFCCFG_RST_WORD;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc & ~mapped;
      o_prdata <= (acc & ~i_pwrite) ? rd : `NFCCFG_RST_WORD;
    end
  end

  // Writes land in the cycle pready is asserted
  wire wt = i_psel & i_penable & o_pready & i_pwrite;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      misc_q <= `NFCCFG_RST_BYTE;
      rsvd_ef_q <= `NFCCFG_RST_BYTE;
      kind_q <= `NFCCFG_RST_BYTE;
      group_q <= `NFCCFG_RST_BYTE;
      swap_q <= `NFCCFG_RST_BYTE;
      count_q <= `NFCCFG_RST_BYTE;
      tech_q <= `NFCCFG_RST_WORD;
      sys_q <= `NFCCFG_RST_WORD;
      test_en_q <= 1'b0;
      dsel_q <= 3'h0;
    end else if (wt) begin
      case (ws)
        `NFCCFG_MISC_CONTROL: misc_q <= wb;
        `NFCCFG_RESERVED_EF: rsvd_ef_q <= wb;
        `NFCCFG_TEST_OUTPUT_KIND: kind_q <= wb;
        `NFCCFG_TEST_SIGNAL_GROUP: begin
          // Codes invalid for the current kind are dropped silently,
          // so software writes the kind first.
          if (group_ok(kind_q, wb))
            group_q <= wb;
        end
        `NFCCFG_TEST_LINE_SWAP: swap_q <= wb;
        `NFCCFG_PAD_ROUTE_COUNT: count_q <= wb;
        `NFCCFG_TECH_MASK: tech_q <= i_pwdata;
        `NFCCFG_SYS_TRIM: sys_q <= i_pwdata;
        `NFCCFG_TEST_ENABLE: test_en_q <= i_pwdata[0];
        `NFCCFG_DELAY_SELECT: dsel_q <= i_pwdata[2:0];
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_dly
      always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n)
          dly_q[g] <= `NFCCFG_RST_BYTE;
        else if (wt && ws == `NFCCFG_TYPE_A_DELAY_BASE + g)
          dly_q[g] <= wb;
      end
    end
    for (g = 0; g < 4; g = g + 1) begin : g_rte
      always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n)
          route_q[g] <= `NFCCFG_RST_BYTE;
        else if (wt && ws == `NFCCFG_PAD_ROUTE_ENTRY0 + g)
          route_q[g] <= wb;
      end
    end
  endgenerate

  // ========================================================================
  // Delay derivation from the technology bitmask
  reg [10:0] dly_d;
  always @* begin
    dly_d = 11'h000;
    case (dsel_q)
      3'h0: dly_d = scale_dly(dly_q[0], a_rate(tech_q[19:16]));
      3'h1: begin
        if (tech_q[`NFCCFG_TECH_B_LO + 3])
          dly_d = {3'h0, dly_q[1]};
        else if (tech_q[`NFCCFG_TECH_B_LO + 2])
          dly_d = scale_dly(dly_q[1], 2'd1);
        else if (tech_q[`NFCCFG_TECH_B_LO + 1])
          dly_d = scale_dly(dly_q[1], 2'd2);
        else if (tech_q[`NFCCFG_TECH_B_LO])
          dly_d = scale_dly(dly_q[1], 2'd3);
      end
      3'h2: begin
        if (tech_q[`NFCCFG_TECH_F424])
          dly_d = {3'h0, dly_q[2]};
        else if (tech_q[`NFCCFG_TECH_F212])
          dly_d = scale_dly(dly_q[2], 2'd1);
      end
      3'h3: begin
        if (tech_q[`NFCCFG_TECH_V100])
          dly_d = {3'h0, dly_q[3]};
        else if (tech_q[`NFCCFG_TECH_V10])
          dly_d = scale_dly(dly_q[3], 2'd1);
      end
      3'h4: dly_d = tech_q[`NFCCFG_TECH_M3] ? {3'h0, dly_q[4]} : 11'h000;
      3'h5: dly_d = tech_q[`NFCCFG_TECH_M3] ? {3'h0, dly_q[5]} : 11'h000;
      default: dly_d = 11'h000;
    endcase
  end

  // ========================================================================
  // Decoded outputs
  // Swap 0 copies line zero onto line one, 1 copies line one onto zero
  wire [7:0] tb_map = swap_q[0] ? {i_test_bus[7:2], i_test_bus[1],
    i_test_bus[1]} : {i_test_bus[7:2], i_test_bus[0], i_test_bus[0]};

  // Each pad takes the last counted entry that names it
  wire [3:0] pad_d;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pad
      reg pad_bit;
      integer k;
      always @* begin
        pad_bit = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
          if (k < count_q && route_hit(route_q[k], g))
            pad_bit = tb_map[route_q[k][2:0]];
        end
      end
      assign pad_d[g] = pad_bit;
    end
  endgenerate

  reg [7:0] trim_d;
  always @* begin
    trim_d = i_stored_trim;
    if (misc_q[`NFCCFG_MISC_TRIM_CORR])
      trim_d = i_stored_trim + sys_q[19:12];
  end

  // ========================================================================
  // Registered outputs, so every port comes from a flip-flop

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_auto_delay_enable <= 1'b0;
      o_timer_select <= 3'h0;
      o_regulated_output_pin <= 1'b0;
      o_gain_trim <= `NFCCFG_RST_BYTE;
      o_active_delay <= 11'h000;
      o_analog_test_output <= 1'b0;
      o_digital_test_output <= 1'b0;
      o_test_pad_out <= 4'h0;
    end else begin
      o_auto_delay_enable <= misc_q[`NFCCFG_MISC_DELAY_EN];
      o_timer_select <= timer_onehot(misc_q[2:1]);
      o_regulated_output_pin <= misc_q[`NFCCFG_MISC_REG_OUT];
      o_gain_trim <= trim_d;
      o_active_delay <= misc_q[`NFCCFG_MISC_DELAY_EN] ? dly_d : 11'h000;
      o_analog_test_output <= test_en_q &&
        kind_q == `NFCCFG_KIND_ANALOG;
      o_digital_test_output <= test_en_q &&
        kind_q == `NFCCFG_KIND_DIGITAL;
      o_test_pad_out <= test_en_q ? pad_d : 4'h0;
    end
  end

endmodule

// ==== sim/nfccfg_store_properties.sv ====
// Port checker for the configuration store.
// Assumes bind onto nfccfg_store, one clock, async active-low reset.
`timescale 1ns/1ps
module nfccfg_props (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_auto_delay_enable,
  input wire [2:0] o_timer_select,
  input wire [10:0] o_active_delay,
  input wire o_analog_test_output,
  input wire o_digital_test_output
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence access_start;
    i_psel && i_penable && !$past(i_penable);
  endsequence
  sequence delay_off;
    !o_auto_delay_enable [*2];
  endsequence
  // ==========================================================
  // Properties
  ready_answer_a: assert property (access_start |-> !o_pready ##1 o_pready)
    else $error("ready not one cycle after access start");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready without access phase");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slave error outside ready cycle");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero while idle");
  timer_onehot_a: assert property ($onehot0(o_timer_select))
    else $error("timer select not one-hot");
  kind_exclusive_a: assert property (
    !(o_analog_test_output && o_digital_test_output))
    else $error("analog and digital test output together");
  delay_gate_a: assert property (
    delay_off |-> o_active_delay == 11'h000)
    else $error("delay applied while disabled");
endmodule

bind nfccfg_store nfccfg_props u_props (
  .i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_auto_delay_enable(o_auto_delay_enable),
  .o_timer_select(o_timer_select),
  .o_active_delay(o_active_delay),
  .o_analog_test_output(o_analog_test_output),
  .o_digital_test_output(o_digital_test_output)
);

// ==== sim/nfccfg_tb.sv ====
// Self-checking bench for the configuration store.
// Assumes the store and its checker are compiled before this file.
`timescale 1ns/1ps
`include "nfccfg_defines.vh"
module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] tbus = 8'h00;
  reg [7:0] strim = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, ade, rop, ana, dig;
  wire [2:0] tsel;
  wire [7:0] trim;
  wire [10:0] dly;
  wire [3:0] pads;
  integer fails = 0;
  integer comparisons = 0;
  reg [31:0] rdat;
  reg rerr;
  reg [10:0] e;
  reg [7:0] base_t [0:5] = '{8'hff, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d};
  int sel_t [14] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 4, 5};
  int bit_t [14] = '{19, 18, 17, 16, 23, 22, 21, 20, 25, 24, 26, 27, 28, 28};
  int sh_t [14] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 0, 1, 0, 0};
  always #5 clk = ~clk;
  nfccfg_store uut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_test_bus(tbus), .i_stored_trim(strim),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_auto_delay_enable(ade), .o_timer_select(tsel),
    .o_regulated_output_pin(rop), .o_gain_trim(trim),
    .o_active_delay(dly), .o_analog_test_output(ana),
    .o_digital_test_output(dig), .o_test_pad_out(pads));
  // ==========================================================
  // Shared tasks
  task print_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // Offsets are word indices, so the byte address is four times them
  task apb(input wr, input [11:0] off, input [31:0] wd);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= off << 2;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 20) begin
        fails = fails + 1;
        print_verdict;
      end else begin
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
      end
    end
  endtask
  task wr(input [11:0] off, input [31:0] d);
    apb(1'b1, off, d);
  endtask
  task rchk(input [11:0] off, input [31:0] exp);
    begin
      apb(1'b0, off, 32'h0);
      chk(rdat, exp);
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      chk({ade, rop, ana, dig, tsel, pads, trim, dly}, 32'h0);
      rchk(`NFCCFG_MISC_CONTROL, 32'h0);
      wr(`NFCCFG_RESERVED_EF, 32'h5a);
      rchk(`NFCCFG_RESERVED_EF, 32'h5a);
      $display("reset test done");
    end
  endtask
  task t_misc;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        wr(`NFCCFG_MISC_CONTROL, {24'h0, 3'b111, 2'b01, c[1:0], 1'b1});
        settle;
        chk(tsel, (c == 3) ? 0 : (1 << c));
        chk({ade, rop}, 2'b11);
        rchk(`NFCCFG_MISC_CONTROL, {3'b111, 2'b01, c[1:0], 1'b1});
      end
      wr(`NFCCFG_MISC_CONTROL, 32'h0);
      settle;
      chk({ade, rop}, 2'b00);
      $display("misc test done");
    end
  endtask
  task t_trim;
    begin
      @(posedge clk);
      strim <= 8'hf0;
      wr(`NFCCFG_SYS_TRIM, 32'h0002_0000);
      wr(`NFCCFG_MISC_CONTROL, 32'h10);
      settle;
      chk(trim, 8'h10);
      wr(`NFCCFG_MISC_CONTROL, 32'h00);
      settle;
      chk(trim, 8'hf0);
      $display("trim test done");
    end
  endtask
  task t_delay;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1)
        wr(`NFCCFG_TYPE_A_DELAY_BASE + i, {24'h0, base_t[i]});
      wr(`NFCCFG_MISC_CONTROL, 32'h01);
      for (i = 0; i < 14; i = i + 1) begin
        wr(`NFCCFG_DELAY_SELECT, sel_t[i]);
        wr(`NFCCFG_TECH_MASK, 32'he000_0000 | (32'h1 << bit_t[i]));
        settle;
        e = base_t[sel_t[i]];
        e = e << sh_t[i];
        chk(dly, e);
        rchk(`NFCCFG_DELAY_RESULT, e);
      end
      rchk(`NFCCFG_TECH_MASK, 32'hf000_0000);
      wr(`NFCCFG_MISC_CONTROL, 32'h00);
      settle;
      chk(dly, 11'h000);
      $display("delay test done");
    end
  endtask
  task t_unmapped;
    begin
      wr(12'h0f8, 32'h55);
      chk(rerr, 1'b1);
      rchk(`NFCCFG_RESERVED_EF, 32'h5a);
      $display("unmapped test done");
    end
  endtask
  task t_testbus;
    begin
      wr(`NFCCFG_TEST_ENABLE, 32'h1);
      wr(`NFCCFG_TEST_OUTPUT_KIND, 32'h1);
      settle;
      chk({ana, dig}, 2'b10);
      wr(`NFCCFG_TEST_OUTPUT_KIND, 32'h2);
      wr(`NFCCFG_TEST_SIGNAL_GROUP, 32'h1b);
      wr(`NFCCFG_TEST_SIGNAL_GROUP, 32'h08);
      rchk(`NFCCFG_TEST_SIGNAL_GROUP, 32'h1b);
      @(posedge clk);
      tbus <= 8'h08;
      wr(`NFCCFG_PAD_ROUTE_ENTRY0, 32'h23);
      wr(`NFCCFG_PAD_ROUTE_COUNT, 32'h1);
      settle;
      chk({ana, dig, pads}, 6'b01_0100);
      wr(`NFCCFG_PAD_ROUTE_COUNT, 32'h0);
      settle;
      chk(pads, 4'h0);
      wr(`NFCCFG_PAD_ROUTE_COUNT, 32'h1);
      @(posedge clk);
      tbus <= 8'h02;
      wr(`NFCCFG_PAD_ROUTE_ENTRY0, 32'h20);
      wr(`NFCCFG_TEST_LINE_SWAP, 32'h1);
      settle;
      chk(pads, 4'h4);
      wr(`NFCCFG_TEST_LINE_SWAP, 32'h0);
      settle;
      chk(pads, 4'h0);
      wr(`NFCCFG_TEST_ENABLE, 32'h0);
      settle;
      chk({dig, pads}, 5'h00);
      $display("test bus test done");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_misc;
    t_trim;
    t_delay;
    t_unmapped;
    t_testbus;
    print_verdict;
  end
endmodule
